//--- hw/lsts_regs.vh
`ifndef LSTS_REGS_VH
`define LSTS_REGS_VH
// ***********************************************
// Register offsets (byte addresses)
// ***********************************************
`define LSTS_OFF_CTRL 12'h000
`define LSTS_OFF_STATUS 12'h004
`define LSTS_OFF_TIMEOUT 12'h008
`define LSTS_OFF_PULSE 12'h00c
`define LSTS_OFF_LOOPS 12'h010
`define LSTS_OFF_SKIP 12'h014
`define LSTS_OFF_POINTS 12'h018
`define LSTS_OFF_ENTRY 12'h01c
`define LSTS_OFF_LEVEL 12'h020
`define LSTS_OFF_COPY 12'h024
// ***********************************************
// Command register bits
// ***********************************************
`define LSTS_CTRL_RUN 0
`define LSTS_CTRL_CLEAR 1
`define LSTS_CTRL_APPEND 2
`define LSTS_CTRL_LEVEL_GEN 3
`define LSTS_CTRL_COPY 4
`define LSTS_CTRL_POL 5
// ***********************************************
// Entry field layout: [17:16] kind, [15:0] level
// ***********************************************
`define LSTS_KIND_LSB 16
`define LSTS_KIND_MSB 17
`define LSTS_KIND_DWELL 2'h0
`define LSTS_KIND_WAIT_HI 2'h1
`define LSTS_KIND_WAIT_LO 2'h2
`define LSTS_KIND_PULSE 2'h3
// ***********************************************
// Depth, widths and timing
// ***********************************************
`define LSTS_DEPTH 8192
`define LSTS_AW 13
`define LSTS_LEVEL_POINTS 13'h000a
`define LSTS_CLK_HZ 40000000
`define LSTS_MS_CYCLES 40000
`define LSTS_TIMEOUT_MAX_US 33300
`define LSTS_TIMEOUT_MAX_CYC 24'h145320
`define LSTS_STABLE_US_X10 4
`define LSTS_STABLE_CYC 24'h003e80
`define LSTS_RESET_PULSE 24'h009c40
`endif

//--- hw/lsts_sequencer.v
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "lsts_regs.vh"
module lsts_sequencer #(
  parameter [23:0] STABLE_CYC = `LSTS_STABLE_CYC,
  parameter [23:0] TIMEOUT_MAX_CYC = `LSTS_TIMEOUT_MAX_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Trigger input pin
  input wire trig_in,
  // Output level, flag transistor and run status
  output reg [15:0] level_out,
  output reg flag_emitter_o,
  output reg flag_emitter_oe_n,
  output reg running
);
  // ***********************************************
  // States
  // ***********************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_LOAD = 3'd1;
  localparam [2:0] S_STEP = 3'd2;
  localparam [2:0] S_NEXT = 3'd3;
  localparam [2:0] S_COPY = 3'd4;
  localparam [2:0] S_GEN = 3'd5;

  function [23:0] clamp_to;
    input [23:0] v;
    input [23:0] lim;
    begin
      clamp_to = (v > lim) ? lim : v;
    end
  endfunction

  reg [17:0] mem [0:`LSTS_DEPTH-1];
  reg [2:0] state_q;
  reg [12:0] points_q;
  reg [12:0] idx_q;
  reg [17:0] cur_q;
  reg [23:0] timeout_q;
  reg [23:0] pulse_q;
  reg [15:0] loops_q;
  reg [15:0] loop_cnt_q;
  reg [12:0] skip_q;
  reg [17:0] entry_q;
  reg [15:0] gen_level_q;
  reg [12:0] copy_lo_q;
  reg [12:0] copy_hi_q;
  reg [12:0] copy_src_q;
  reg [15:0] copy_val_q;
  reg [3:0] gen_cnt_q;
  reg pol_q;
  reg [23:0] tmr_q;
  reg [23:0] dwell_q;
  reg [23:0] stab_q;
  reg sync1_q, sync2_q, filt_q;
  reg [17:0] rd_q;
  reg [12:0] rd_idx_q;
  reg wr_pend_q;
  reg [17:0] wr_data_q;

  wire acc = psel && penable && !pready;
  // Writes land at the edge that completes the transfer
  wire wr = psel && penable && pwrite && pready;
  wire mem_free = (state_q == S_IDLE);
  wire pulse_on = (state_q == S_STEP) && (cur_q[`LSTS_KIND_MSB:`LSTS_KIND_LSB] == `LSTS_KIND_PULSE);

  // ***********************************************
  // Trigger synchroniser and stability filter
  // ***********************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      filt_q <= 1'b0;
      stab_q <= 24'h000000;
    end else begin
      sync1_q <= trig_in;
      sync2_q <= sync1_q;
      // Noise rejection: a level counts only after it holds
      if (sync2_q == filt_q) begin
        stab_q <= 24'h000000;
      end else if (stab_q >= STABLE_CYC - 24'h000001) begin
        filt_q <= sync2_q;
        stab_q <= 24'h000000;
      end else begin
        stab_q <= stab_q + 24'h000001;
      end
    end
  end

  // ***********************************************
  // APB registers, list memory and sequencer
  // ***********************************************
  always @(posedge ref_clk) begin
    if (wr_pend_q) begin
      mem[points_q] <= wr_data_q;
    end
    rd_q <= mem[idx_q];
    rd_idx_q <= idx_q;
  end

  wire append_ok = wr_pend_q && (points_q != 13'h1fff);

  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state_q <= S_IDLE;
      points_q <= 13'h0000;
      idx_q <= 13'h0000;
      cur_q <= 18'h00000;
      timeout_q <= 24'h000000;
      pulse_q <= `LSTS_RESET_PULSE;
      loops_q <= 16'h0001;
      loop_cnt_q <= 16'h0000;
      skip_q <= 13'h0000;
      entry_q <= 18'h00000;
      gen_level_q <= 16'h0000;
      copy_lo_q <= 13'h0000;
      copy_hi_q <= 13'h0000;
      copy_src_q <= 13'h0000;
      copy_val_q <= 16'h0000;
      gen_cnt_q <= 4'h0;
      pol_q <= 1'b1;
      tmr_q <= 24'h000000;
      dwell_q <= 24'h000001;
      wr_pend_q <= 1'b0;
      wr_data_q <= 18'h00000;
      level_out <= 16'h0000;
      flag_emitter_o <= 1'b0;
      flag_emitter_oe_n <= 1'b1;
      running <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      wr_pend_q <= 1'b0;
      if (append_ok) begin
        points_q <= points_q + 13'h0001;
      end
      if (acc && !pwrite) begin
        prdata <= 32'h00000000;
        if (paddr == `LSTS_OFF_STATUS) begin
          prdata <= {16'h0000, loop_cnt_q[7:0], filt_q, 4'h0, state_q};
        end else if (paddr == `LSTS_OFF_TIMEOUT) begin
          prdata <= {8'h00, timeout_q};
        end else if (paddr == `LSTS_OFF_PULSE) begin
          prdata <= {8'h00, pulse_q};
        end else if (paddr == `LSTS_OFF_LOOPS) begin
          prdata <= {16'h0000, loops_q};
        end else if (paddr == `LSTS_OFF_SKIP) begin
          prdata <= {19'h00000, skip_q};
        end else if (paddr == `LSTS_OFF_POINTS) begin
          prdata <= {19'h00000, points_q};
        end else if (paddr == `LSTS_OFF_ENTRY) begin
          prdata <= {14'h0000, entry_q};
        end else if (paddr == `LSTS_OFF_LEVEL) begin
          prdata <= {16'h0000, level_out};
        end else if (paddr == `LSTS_OFF_CTRL) begin
          prdata <= {26'h0000000, pol_q, 4'h0, running};
        end else begin
          pslverr <= 1'b1;
        end
      end
      if (wr) begin
        if (paddr == `LSTS_OFF_TIMEOUT) begin
          timeout_q <= clamp_to(pwdata[23:0], TIMEOUT_MAX_CYC);
        end else if (paddr == `LSTS_OFF_PULSE) begin
          pulse_q <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
        end else if (paddr == `LSTS_OFF_LOOPS) begin
          loops_q <= pwdata[15:0];
        end else if (paddr == `LSTS_OFF_SKIP) begin
          skip_q <= pwdata[12:0];
        end else if (paddr == `LSTS_OFF_ENTRY) begin
          entry_q <= pwdata[17:0];
        end else if (paddr == `LSTS_OFF_LEVEL) begin
          gen_level_q <= pwdata[15:0];
          dwell_q <= (pwdata[31:16] == 16'h0000) ? 24'h000001 : {8'h00, pwdata[31:16]};
        end else if (paddr == `LSTS_OFF_COPY) begin
          copy_lo_q <= pwdata[12:0];
          copy_hi_q <= pwdata[28:16];
        end else if (paddr == `LSTS_OFF_CTRL) begin
          pol_q <= pwdata[`LSTS_CTRL_POL];
          if (pwdata[`LSTS_CTRL_CLEAR] && mem_free) begin
            points_q <= 13'h0000;
          end else if (pwdata[`LSTS_CTRL_APPEND] && mem_free) begin
            wr_pend_q <= 1'b1;
            wr_data_q <= entry_q;
          end else if (pwdata[`LSTS_CTRL_LEVEL_GEN] && mem_free) begin
            gen_cnt_q <= 4'h0;
            state_q <= S_GEN;
          end else if (pwdata[`LSTS_CTRL_COPY] && mem_free) begin
            copy_src_q <= copy_lo_q;
            copy_val_q <= entry_q[15:0];
            idx_q <= copy_lo_q;
            state_q <= S_COPY;
          end else if (pwdata[`LSTS_CTRL_RUN] && mem_free && points_q != 13'h0000) begin
            idx_q <= 13'h0000;
            loop_cnt_q <= 16'h0000;
            running <= 1'b1;
            state_q <= S_LOAD;
          end else if (!pwdata[`LSTS_CTRL_RUN]) begin
            running <= 1'b0;
            state_q <= (state_q == S_COPY || state_q == S_GEN) ? state_q : S_IDLE;
          end
        end
      end
      case (state_q)
        S_GEN: begin
          // Ten constant points per short level request
          wr_pend_q <= 1'b1;
          wr_data_q <= {`LSTS_KIND_DWELL, gen_level_q};
          gen_cnt_q <= gen_cnt_q + 4'h1;
          if ({9'h000, gen_cnt_q} == `LSTS_LEVEL_POINTS - 13'h0001) begin
            state_q <= S_IDLE;
          end
        end
        S_COPY: begin
          // One idle cycle between reads keeps rd_q aligned with copy_src_q
          if (!wr_pend_q && idx_q == copy_src_q && rd_idx_q == copy_src_q) begin
            wr_pend_q <= 1'b1;
            wr_data_q <= {rd_q[17:16], copy_val_q};
            if (copy_src_q == copy_hi_q) begin
              state_q <= S_IDLE;
            end else begin
              copy_src_q <= copy_src_q + 13'h0001;
              idx_q <= copy_src_q + 13'h0001;
            end
          end
        end
        S_LOAD: begin
          state_q <= S_NEXT;
        end
        S_NEXT: begin
          cur_q <= rd_q;
          level_out <= rd_q[15:0];
          tmr_q <= 24'h000000;
          state_q <= S_STEP;
        end
        S_STEP: begin
          tmr_q <= tmr_q + 24'h000001;
          if ((cur_q[`LSTS_KIND_MSB:`LSTS_KIND_LSB] == `LSTS_KIND_WAIT_HI && filt_q) ||
              (cur_q[`LSTS_KIND_MSB:`LSTS_KIND_LSB] == `LSTS_KIND_WAIT_LO && !filt_q) ||
              (cur_q[17] ^ cur_q[16] && timeout_q != 24'h000000 && tmr_q >= timeout_q - 24'h000001) ||
              (cur_q[`LSTS_KIND_MSB:`LSTS_KIND_LSB] == `LSTS_KIND_DWELL && tmr_q >= dwell_q - 24'h000001) ||
              (pulse_on && tmr_q >= pulse_q - 24'h000001)) begin
            if (idx_q + 13'h0001 < points_q) begin
              idx_q <= idx_q + 13'h0001;
              state_q <= S_LOAD;
            end else if (loop_cnt_q + 16'h0001 < loops_q) begin
              loop_cnt_q <= loop_cnt_q + 16'h0001;
              idx_q <= (skip_q < points_q) ? skip_q : 13'h0000;
              state_q <= S_LOAD;
            end else begin
              running <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
      // Output transistor: on means pin pulled low, off means released
      flag_emitter_o <= 1'b0;
      flag_emitter_oe_n <= !(pulse_on == pol_q);
    end
  end
endmodule

//--- verification/lsts_checker.sv
`timescale 1ns/1ps
// ****
// Bus, flag and run checks
// ****
module lsts_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Outputs
  input wire flag_emitter_o,
  input wire flag_emitter_oe_n,
  input wire running
);
  wire req = psel && penable && !pready;
  // Running may lag the start write by one to three cycles
  wire go_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_answer_a: assert property (req |=> pready) else $error("no answer");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  err_unmapped_a: assert property (req && !pwrite && paddr == 12'h028 |=> pslverr)
    else $error("unmapped read accepted");
  err_points_a: assert property (req && paddr == 12'h018 |=> !pslverr)
    else $error("count query refused");
  emit_low_a: assert property (!flag_emitter_o) else $error("flag driven high");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !running && flag_emitter_oe_n)
    else $error("bad reset state");
  run_cause_a: assert property ($rose(running) |-> $past(go_wr) || $past(go_wr, 2) || $past(go_wr, 3))
    else $error("run without start");
endmodule
bind lsts_sequencer lsts_checker i_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .flag_emitter_o(flag_emitter_o), .flag_emitter_oe_n(flag_emitter_oe_n), .running(running));

//--- verification/lsts_far_side.sv
`timescale 1ns/1ps
// ****
// Pulse source and measuring instrument
// ****
module lsts_far_side (
  // Clock and bench controls
  input wire ref_clk,
  input wire host_hi,
  input wire [15:0] resp_cyc,
  // Flag and trigger wires
  input wire flag_emitter_oe_n,
  output wire trig_in
);
  reg [15:0] low_cnt = 16'h0000;
  reg oe_n_q = 1'b1;
  always @(posedge ref_clk) begin
    oe_n_q <= flag_emitter_oe_n;
    if (oe_n_q && !flag_emitter_oe_n) begin
      low_cnt <= resp_cyc;
    end else if (low_cnt != 16'h0000) begin
      low_cnt <= low_cnt - 16'h0001;
    end
  end
  // Instrument holds the line low while it measures
  assign trig_in = host_hi && (low_cnt == 16'h0000);
endmodule

//--- verification/tb_lsts_sequencer.sv
`timescale 1ns/1ps
module tb_lsts_sequencer;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg host_hi = 1'b0;
  reg [15:0] resp_cyc = 16'h0028;
  reg [31:0] rd;
  reg rerr;
  wire [31:0] prdata;
  wire [15:0] level_out;
  wire pready, pslverr, trig_in, flag_emitter_o, flag_emitter_oe_n, running;
  integer err_total = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  integer lows;
  always #12.5 ref_clk = ~ref_clk;
  // Short filter and timeout ceiling keep the run brief
  lsts_sequencer #(.STABLE_CYC(24'h000004), .TIMEOUT_MAX_CYC(24'h000064)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .level_out(level_out),
    .flag_emitter_o(flag_emitter_o), .flag_emitter_oe_n(flag_emitter_oe_n), .running(running));
  lsts_far_side i_far (.ref_clk(ref_clk), .host_hi(host_hi), .resp_cyc(resp_cyc),
    .flag_emitter_oe_n(flag_emitter_oe_n), .trig_in(trig_in));
  // ****
  // Shared tasks
  // ****
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task push(input [1:0] k, input [15:0] lv);
    begin
      apb(1'b1, 12'h01c, {14'h0000, k, lv});
      apb(1'b1, 12'h000, 32'h00000024);
    end
  endtask
  task idle;
    begin
      rd = 32'h00000001;
      while (rd[2:0] !== 3'h0) apb(1'b0, 12'h004, 32'h00000000);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    begin
      apb(1'b0, 12'h008, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b1, 12'h008, 32'h0000ffff);
      apb(1'b0, 12'h008, 32'h00000000);
      check(rd, 32'h00000064);
      apb(1'b0, 12'h028, 32'h00000000);
      check({31'h00000000, rerr}, 32'h00000001);
      apb(1'b1, 12'h000, 32'h00000022);
      apb(1'b1, 12'h020, 32'h00050033);
      apb(1'b1, 12'h000, 32'h00000028);
      idle;
      apb(1'b0, 12'h018, 32'h00000000);
      check(rd, 32'h0000000a);
      $display("test regs done");
    end
  endtask
  task t_wait;
    begin
      apb(1'b1, 12'h008, 32'h00000000);
      apb(1'b1, 12'h000, 32'h00000022);
      push(2'h1, 16'h0011);
      push(2'h2, 16'h0011);
      apb(1'b1, 12'h024, 32'h00010000);
      apb(1'b1, 12'h01c, 32'h00000022);
      apb(1'b1, 12'h000, 32'h00000030);
      idle;
      apb(1'b0, 12'h018, 32'h00000000);
      check(rd, 32'h00000004);
      apb(1'b1, 12'h000, 32'h00000021);
      repeat (200) @(posedge ref_clk);
      check({16'h0000, level_out}, 32'h00000011);
      check({31'h00000000, running}, 32'h00000001);
      // Host pulse held well past the filter time
      host_hi <= 1'b1;
      repeat (40) @(posedge ref_clk);
      check({16'h0000, level_out}, 32'h00000011);
      host_hi <= 1'b0;
      repeat (40) @(posedge ref_clk);
      check({16'h0000, level_out}, 32'h00000022);
      host_hi <= 1'b1;
      repeat (40) @(posedge ref_clk);
      host_hi <= 1'b0;
      repeat (40) @(posedge ref_clk);
      check({31'h00000000, running}, 32'h00000000);
      $display("test wait done");
    end
  endtask
  task t_timeout;
    begin
      apb(1'b1, 12'h000, 32'h00000022);
      apb(1'b1, 12'h008, 32'h00000032);
      apb(1'b1, 12'h010, 32'h00000003);
      apb(1'b1, 12'h014, 32'h00000001);
      push(2'h1, 16'h0044);
      push(2'h1, 16'h0055);
      apb(1'b1, 12'h000, 32'h00000021);
      repeat (175) @(posedge ref_clk);
      check({31'h00000000, running}, 32'h00000001);
      repeat (85) @(posedge ref_clk);
      check({31'h00000000, running}, 32'h00000000);
      $display("test timeout done");
    end
  endtask
  task t_pulse;
    begin
      apb(1'b1, 12'h000, 32'h00000022);
      apb(1'b1, 12'h008, 32'h00000000);
      apb(1'b1, 12'h010, 32'h00000001);
      apb(1'b1, 12'h014, 32'h00000000);
      apb(1'b1, 12'h00c, 32'h00000014);
      push(2'h3, 16'h0066);
      push(2'h1, 16'h0077);
      host_hi <= 1'b1;
      check({31'h00000000, flag_emitter_oe_n}, 32'h00000001);
      apb(1'b1, 12'h000, 32'h00000021);
      lows = 0;
      for (i = 0; i < 70; i = i + 1) begin
        @(posedge ref_clk);
        if (flag_emitter_oe_n === 1'b0) lows = lows + 1;
        if (i == 10) check({16'h0000, level_out}, 32'h00000066);
        if (i == 35) check({16'h0000, level_out}, 32'h00000077);
      end
      check(lows, 32'h00000014);
      check({31'h00000000, flag_emitter_oe_n}, 32'h00000001);
      check({31'h00000000, running}, 32'h00000000);
      $display("test pulse done");
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_wait;
    t_timeout;
    t_pulse;
    complete_run;
  end
endmodule
